/* File: logic/rcw_cfg_mem.sv */
// Special configuration word store with registered read port
`timescale 1ns/10ps
`default_nettype none
module rcw_cfg_mem
	import rcw_pkg::*;
(
	input  wire logic                sys_clk,  // System clock
	input  wire logic                rst_n,    // Async reset, low
	input  wire logic                clk_en,   // Freezes state when low
	input  wire logic                wr_en,    // Write strobe
	input  wire logic [MEM_AW-1:0]   wr_addr,  // Write word index
	input  wire logic [WORD_W-1:0]   wr_data,  // Write data
	input  wire logic                erase,    // Bulk erase strobe
	input  wire logic                rd_en,    // Read strobe
	input  wire logic                rd_zero,  // Read returns zero
	input  wire logic [MEM_AW-1:0]   rd_addr,  // Read word index
	output logic      [WORD_W-1:0]   rd_data   // Registered read data
);
	logic [WORD_W-1:0] mem [MEM_DEPTH];
	logic [WORD_W-1:0] rd_data_next;

	genvar i;
	generate
		for (i = 0; i < MEM_DEPTH; i++) begin : g_word
			logic [WORD_W-1:0] word_next;
			always_comb begin
				word_next = mem[i];
				// Factory calibration survives the bulk erase
				if (erase && (MEM_AW'(i) != CAL_IDX)) begin
					word_next = ERASED_WORD;
				end else if (wr_en && (wr_addr == MEM_AW'(i))) begin
					word_next = wr_data;
				end
			end
			// Nonvolatile contents: no reset on purpose
			always_ff @(posedge sys_clk) begin
				if (clk_en) begin
					mem[i] <= word_next;
				end
			end
		end
	endgenerate

	always_comb begin
		rd_data_next = rd_data;
		if (rd_en) begin
			rd_data_next = rd_zero ? '0 : mem[rd_addr];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= '0;
		end else if (clk_en) begin
			rd_data <= rd_data_next;
		end
	end
endmodule
`default_nettype wire

/* File: logic/rcw_pkg.sv */
// Constants and types for the reset and configuration word logic
package rcw_pkg;
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned WORD_W        = 16;
	localparam int unsigned ADDR_W        = 14;
	localparam int unsigned MEM_AW        = 4;
	localparam int unsigned MEM_DEPTH     = 16;

	localparam logic [13:0] CFG_ADDR   = 14'h2007;
	localparam logic [13:0] CAL_ADDR   = 14'h2009;
	localparam logic [13:0] SPACE_BASE = 14'h2000;
	localparam int unsigned SPACE_BIT  = 13;
	localparam logic [3:0]  CFG_IDX    = CFG_ADDR[3:0];
	localparam logic [3:0]  CAL_IDX    = CAL_ADDR[3:0];

	localparam int unsigned BOR_SEL_HI = 9;
	localparam int unsigned BOR_SEL_LO = 8;
	localparam int unsigned INTERNAL_OSC_FREQ_SELECT_BIT = 7;
	localparam int unsigned CP_BIT     = 6;
	localparam int unsigned PINSEL_BIT = 5;
	localparam int unsigned POWER_UP_DELAY_ENABLE_BIT  = 4;
	localparam int unsigned WATCHDOG_ENABLE_BIT   = 3;
	localparam int unsigned FOSC_HI    = 2;
	localparam int unsigned FOSC_LO    = 0;
	localparam logic [15:0] UNIMPL_MASK = 16'hfc00;
	localparam logic [15:0] ERASED_WORD = 16'hffff;
	localparam logic [15:0] CFG_RESET   = 16'hffff;
	localparam logic [1:0]  BOR_ALWAYS  = 2'h3;
	localparam logic [1:0]  BOR_AWAKE   = 2'h2;

	localparam int unsigned POWER_UP_DELAY_TIMER_TIME_NS = 64000000;
	localparam int unsigned POWER_UP_DELAY_TIMER_CYC =
		(POWER_UP_DELAY_TIMER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned POWER_UP_DELAY_TIMER_CNT_W = 20;
	localparam int unsigned OST_TICKS  = 1024;
	localparam int unsigned OST_CNT_W  = 10;
	localparam int unsigned FILT_TIME_NS = 2000;
	localparam int unsigned FILT_CYC =
		(FILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned FILT_CNT_W = 8;

	typedef enum logic [2:0] {
		OSC_LP_XTAL  = 3'h0,
		OSC_STD_XTAL = 3'h1,
		OSC_HS_XTAL  = 3'h2,
		OSC_EXT_CLK  = 3'h3,
		OSC_INT_IO   = 3'h4,
		OSC_INT_CLKO = 3'h5,
		OSC_RC_IO    = 3'h6,
		OSC_RC_CLKO  = 3'h7
	} rcw_osc_type;

	typedef enum logic [5:0] {
		ST_LOAD   = 6'h01,
		ST_SUPPLY = 6'h02,
		ST_POWER_UP_DELAY_TIMER   = 6'h04,
		ST_OST    = 6'h08,
		ST_RUN    = 6'h10,
		ST_HOLD   = 6'h20
	} rcw_state_type;

	localparam rcw_state_type ST_SLEEP_CODE = ST_RUN;
endpackage

/* File: logic/rcw_reset_config.sv */
// Reset sequencer and configuration word decoder
`timescale 1ns/10ps
`default_nettype none
module rcw_reset_config
	import rcw_pkg::*;
#(
	parameter int unsigned POWER_UP_DELAY_TIMER_CYCLES = rcw_pkg::POWER_UP_DELAY_TIMER_CYC
)(
	input  wire logic                      sys_clk,           // Clock
	input  wire logic                      rst_n,             // Power-on
	input  wire logic                      clk_en,            // Enable
	input  wire logic                      supply_ok,         // Above thr
	input  wire logic                      osc_tick,          // Osc period
	input  wire logic                      ext_pin_i,         // Pin level
	output logic                           ext_pin_oe,        // Pin drive
	output logic                           ext_pin_pullup_en, // Pull-up
	output logic                           pin_digital_in,    // Port bit
	input  wire logic                      wdt_timeout,       // Wdog pulse
	input  wire logic                      sleep_req,         // Enter sleep
	input  wire logic                      irq_pending,       // Interrupt
	input  wire logic                      sw_set_por,        // Set flag
	input  wire logic                      prog_mode,         // Prog mode
	input  wire logic [ADDR_W-1:0]         prog_addr,         // Address
	input  wire logic                      prog_we,           // Write
	input  wire logic [WORD_W-1:0]         prog_wdata,        // Write data
	input  wire logic                      prog_re,           // Read
	input  wire logic                      bulk_erase,        // Erase
	output logic      [WORD_W-1:0]         prog_rdata,        // Read data
	output logic                           prog_mem_erase,    // Erase out
	output logic                           core_reset,        // Core reset
	output logic                           cold_reset,        // POR only
	output logic                           int_osc_run,       // Osc on
	output logic                           wake_event,        // Woke up
	output logic                           bor_enable,        // Brown-out
	output logic                           wdt_enable,        // Watchdog
	output logic                           int_osc_8mhz,      // 8 MHz
	output logic                           code_protect_on,   // Protect
	output rcw_pkg::rcw_osc_type           osc_mode,          // Clock mode
	output logic                           clkout_en,         // Clock out
	output logic                           por_flag           // Power flag
);
	import rcw_pkg::*;

	localparam logic [POWER_UP_DELAY_TIMER_CNT_W-1:0] POWER_UP_DELAY_TIMER_LAST =
		POWER_UP_DELAY_TIMER_CNT_W'(POWER_UP_DELAY_TIMER_CYCLES - 1);
	localparam logic [OST_CNT_W-1:0]  OST_LAST  = OST_CNT_W'(OST_TICKS - 1);
	localparam logic [FILT_CNT_W-1:0] FILT_LAST = FILT_CNT_W'(FILT_CYC - 1);

	function automatic logic is_crystal(input logic [2:0] fosc);
		return (fosc == OSC_LP_XTAL) || (fosc == OSC_STD_XTAL) ||
			(fosc == OSC_HS_XTAL);
	endfunction

	function automatic logic bor_on(input logic [1:0] sel, input logic slp);
		return (sel == BOR_ALWAYS) || ((sel == BOR_AWAKE) && !slp);
	endfunction

	rcw_state_type           state_reg, state_next;
	logic                    sleep_reg, sleep_next;
	logic [POWER_UP_DELAY_TIMER_CNT_W-1:0]   power_up_delay_timer_cnt_reg, power_up_delay_timer_cnt_next;
	logic [OST_CNT_W-1:0]    ost_cnt_reg, ost_cnt_next;
	logic                    load_reg, load_next;
	logic [WORD_W-1:0]       cfg_reg, cfg_next;
	logic                    seq_reg, seq_next;
	logic                    waking_reg, waking_next;
	logic                    wake_next, cold_next, por_next, erase_next;
	logic [FILT_CNT_W-1:0]   filt_cnt_reg, filt_cnt_next;
	logic                    ext_rst_reg, ext_rst_next;
	logic [2:0]              fosc;
	logic                    pin_sel, power_up_delay_timer_en, xtal, bor_now, wdt_rst;
	logic                    in_space, mapped, mem_we, mem_re, mem_zero;
	logic                    mem_erase;
	logic [MEM_AW-1:0]       idx, mem_raddr;
	logic [WORD_W-1:0]       mem_wdata, mem_rdata;

	assign fosc    = cfg_reg[FOSC_HI:FOSC_LO];
	assign pin_sel = cfg_reg[PINSEL_BIT];
	assign power_up_delay_timer_en = !cfg_reg[POWER_UP_DELAY_ENABLE_BIT];
	assign xtal    = is_crystal(fosc);
	assign bor_now = bor_on(cfg_reg[BOR_SEL_HI:BOR_SEL_LO], sleep_reg);
	assign wdt_rst = wdt_timeout && cfg_reg[WATCHDOG_ENABLE_BIT];

	// Configuration decode
	assign bor_enable      = bor_now;
	assign wdt_enable      = cfg_reg[WATCHDOG_ENABLE_BIT];
	assign int_osc_8mhz    = cfg_reg[INTERNAL_OSC_FREQ_SELECT_BIT];
	assign code_protect_on = !cfg_reg[CP_BIT];
	assign osc_mode        = rcw_osc_type'(fosc);
	assign clkout_en       = (fosc == OSC_RC_CLKO) || (fosc == OSC_INT_CLKO);

	// Pin is input only, whatever the reset source
	assign ext_pin_oe        = 1'b0;
	assign ext_pin_pullup_en = pin_sel;
	assign pin_digital_in    = pin_sel ? 1'b0 : ext_pin_i;
	// Oscillator idles while the pin holds reset in RC or internal modes
	assign int_osc_run = !(ext_rst_reg && fosc[FOSC_HI]);
	assign core_reset  = ((state_reg != ST_RUN) && !waking_reg) ||
		ext_rst_reg;

	// Pin filter: a low must last the full window to count
	always_comb begin
		filt_cnt_next = '0;
		ext_rst_next  = 1'b0;
		if (pin_sel && !ext_pin_i) begin
			filt_cnt_next = filt_cnt_reg;
			ext_rst_next  = ext_rst_reg;
			if (filt_cnt_reg == FILT_LAST) begin
				ext_rst_next = 1'b1;
			end else begin
				filt_cnt_next = filt_cnt_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			filt_cnt_reg <= '0;
			ext_rst_reg  <= 1'b0;
		end else if (clk_en) begin
			filt_cnt_reg <= filt_cnt_next;
			ext_rst_reg  <= ext_rst_next;
		end
	end

	// Programming access to the special space
	assign in_space  = prog_mode && prog_addr[SPACE_BIT];
	assign mapped    = in_space &&
		(prog_addr[SPACE_BIT-1:MEM_AW] == SPACE_BASE[SPACE_BIT-1:MEM_AW]);
	assign idx       = prog_addr[MEM_AW-1:0];
	assign mem_we    = prog_we && mapped;
	// Bits without function are kept erased
	assign mem_wdata = (idx == CFG_IDX) ? (prog_wdata | UNIMPL_MASK) :
		prog_wdata;
	assign mem_erase = bulk_erase && prog_mode;
	assign mem_re    = ((state_reg == ST_LOAD) && !load_reg) ||
		(prog_re && in_space);
	assign mem_raddr = (state_reg == ST_LOAD) ? CFG_IDX : idx;
	assign mem_zero  = (state_reg != ST_LOAD) && !mapped;

	rcw_cfg_mem u_mem (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.clk_en  (clk_en),
		.wr_en   (mem_we),
		.wr_addr (idx),
		.wr_data (mem_wdata),
		.erase   (mem_erase),
		.rd_en   (mem_re),
		.rd_zero (mem_zero),
		.rd_addr (mem_raddr),
		.rd_data (mem_rdata)
	);
	assign prog_rdata = mem_rdata;

	// Sequencer
	always_comb begin
		state_next    = state_reg;
		sleep_next    = sleep_reg;
		power_up_delay_timer_cnt_next = power_up_delay_timer_cnt_reg;
		ost_cnt_next  = ost_cnt_reg;
		load_next     = load_reg;
		cfg_next      = cfg_reg;
		seq_next      = seq_reg;
		waking_next   = waking_reg;
		wake_next     = 1'b0;
		cold_next     = cold_reset;
		por_next      = por_flag || sw_set_por;
		erase_next    = mem_erase || (mem_we && (idx == CFG_IDX) &&
			prog_wdata[CP_BIT] && !cfg_reg[CP_BIT]);
		if (bor_now && !supply_ok && (state_reg != ST_LOAD)) begin
			// Restart the whole power-up chain on brown-out
			state_next    = ST_SUPPLY;
			seq_next      = 1'b1;
			sleep_next    = 1'b0;
			power_up_delay_timer_cnt_next = '0;
			ost_cnt_next  = '0;
			waking_next   = 1'b0;
		end else begin
			case (state_reg)
				ST_LOAD: begin
					load_next = 1'b1;
					if (load_reg) begin
						cfg_next   = mem_rdata;
						state_next = ST_SUPPLY;
					end
				end
				ST_SUPPLY: begin
					if (seq_reg && power_up_delay_timer_en) begin
						state_next = ST_POWER_UP_DELAY_TIMER;
					end else if (seq_reg && xtal) begin
						state_next = ST_OST;
					end else begin
						state_next = ST_RUN;
						seq_next   = 1'b0;
						cold_next  = 1'b0;
					end
				end
				ST_POWER_UP_DELAY_TIMER: begin
					if (power_up_delay_timer_cnt_reg == POWER_UP_DELAY_TIMER_LAST) begin
						power_up_delay_timer_cnt_next = '0;
						if (xtal) begin
							state_next = ST_OST;
						end else begin
							state_next = ST_RUN;
							seq_next   = 1'b0;
							cold_next  = 1'b0;
						end
					end else begin
						power_up_delay_timer_cnt_next = power_up_delay_timer_cnt_reg + 1'b1;
					end
				end
				ST_OST: begin
					if (waking_reg && ext_rst_reg) begin
						state_next  = ST_HOLD;
						waking_next = 1'b0;
						sleep_next  = 1'b0;
						ost_cnt_next = '0;
					end else if (osc_tick) begin
						if (ost_cnt_reg == OST_LAST) begin
							ost_cnt_next = '0;
							state_next   = ST_RUN;
							seq_next     = 1'b0;
							cold_next    = 1'b0;
							wake_next    = waking_reg;
							waking_next  = 1'b0;
							sleep_next   = 1'b0;
						end else begin
							ost_cnt_next = ost_cnt_reg + 1'b1;
						end
					end
				end
				ST_RUN: begin
					if (ext_rst_reg || (wdt_rst && !sleep_reg)) begin
						state_next = ST_HOLD;
						sleep_next = 1'b0;
					end else if (sleep_reg) begin
						// Watchdog wake-up is not a reset
						if (wdt_rst || irq_pending) begin
							if (xtal) begin
								state_next  = ST_OST;
								waking_next = 1'b1;
							end else begin
								sleep_next = 1'b0;
								wake_next  = 1'b1;
							end
						end
					end else if (sleep_req) begin
						sleep_next = 1'b1;
					end
				end
				ST_HOLD: begin
					if (!ext_rst_reg) begin
						state_next = ST_SUPPLY;
					end
				end
				default: begin
					state_next = ST_LOAD;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg      <= ST_LOAD;
			sleep_reg      <= 1'b0;
			power_up_delay_timer_cnt_reg   <= '0;
			ost_cnt_reg    <= '0;
			load_reg       <= 1'b0;
			cfg_reg        <= CFG_RESET;
			seq_reg        <= 1'b1;
			waking_reg     <= 1'b0;
			wake_event     <= 1'b0;
			cold_reset     <= 1'b1;
			por_flag       <= 1'b0;
			prog_mem_erase <= 1'b0;
		end else if (clk_en) begin
			state_reg      <= state_next;
			sleep_reg      <= sleep_next;
			power_up_delay_timer_cnt_reg   <= power_up_delay_timer_cnt_next;
			ost_cnt_reg    <= ost_cnt_next;
			load_reg       <= load_next;
			cfg_reg        <= cfg_next;
			seq_reg        <= seq_next;
			waking_reg     <= waking_next;
			wake_event     <= wake_next;
			cold_reset     <= cold_next;
			por_flag       <= por_next;
			prog_mem_erase <= erase_next;
		end
	end

	a_bor_holds:
	assert property (@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && bor_now && !supply_ok && state_reg == ST_RUN)
		|=> core_reset && state_reg == ST_SUPPLY)
	else $error("brown-out did not hold reset");

	a_power_up_delay_timer_restart:
	assert property (@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && state_reg == ST_POWER_UP_DELAY_TIMER && bor_now && !supply_ok)
		|=> state_reg == ST_SUPPLY && power_up_delay_timer_cnt_reg == '0)
	else $error("power-up delay not restarted");

	a_power_up_delay_timer_end:
	assert property (@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && state_reg == ST_POWER_UP_DELAY_TIMER && power_up_delay_timer_cnt_reg == POWER_UP_DELAY_TIMER_LAST &&
		!(bor_now && !supply_ok))
		|=> state_reg != ST_POWER_UP_DELAY_TIMER && power_up_delay_timer_cnt_reg == '0)
	else $error("power-up delay wrong length");

	a_power_up_delay_timer_off:
	assert property (@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && state_reg == ST_SUPPLY && cfg_reg[POWER_UP_DELAY_ENABLE_BIT])
		|=> state_reg != ST_POWER_UP_DELAY_TIMER)
	else $error("disabled power-up delay ran");

	a_ost_xtal:
	assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state_reg == ST_OST) |-> xtal && (core_reset || waking_reg))
	else $error("start-up timer outside crystal mode");

	a_filter_len:
	assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(ext_rst_reg) |-> $past(filt_cnt_reg) == FILT_LAST &&
		$past(ext_pin_i, 2) == 1'b0)
	else $error("short reset pulse accepted");

	a_pin_tied:
	assert property (@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && !pin_sel) |=> !ext_rst_reg && ext_pin_oe == 1'b0)
	else $error("tied reset input became active");

	a_osc_stop:
	assert property (@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && pin_sel && fosc[FOSC_HI] && !ext_pin_i &&
		filt_cnt_reg == FILT_LAST) |=> !int_osc_run && core_reset)
	else $error("oscillator ran during pin reset");

	a_wake_quiet:
	assert property (@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && state_reg == ST_RUN && sleep_reg && wdt_rst &&
		!ext_rst_reg && !xtal && !(bor_now && !supply_ok))
		|=> !core_reset && wake_event)
	else $error("watchdog wake-up reset the core");

	a_por_set:
	assert property (@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && sw_set_por) |=> por_flag ##1 (por_flag || !clk_en))
	else $error("power-on flag not held");
endmodule
`default_nettype wire

/* File: testbench/rcw_far_side_model.sv */
// Model of the reset pin driver and the supply monitor
`timescale 1ns/10ps
`default_nettype none
module rcw_far_side_model #(
	parameter int unsigned OSC_DIV = 2 // Cycles per crystal period
)(
	input  wire logic sys_clk,           // Clock
	input  wire logic pin_low,           // Bench pulls the pin low
	input  wire logic ext_pin_oe,        // Device drive, open drain
	input  wire logic ext_pin_pullup_en, // Device weak pull-up
	input  wire logic supply_up,         // Bench supply request
	output logic      ext_pin_i,         // Resolved pin level
	output logic      supply_ok,         // Above threshold
	output logic      osc_tick           // Crystal period pulse
);
	logic       float_reg = 1'b0;
	logic [7:0] div_reg = 8'h00;
	// Released pin without pull-up toggles, never a stale level
	always @(posedge sys_clk) begin
		float_reg <= !float_reg;
		div_reg <= (div_reg == 8'(OSC_DIV - 1)) ? 8'h00 : div_reg + 8'h01;
	end
	assign ext_pin_i = (pin_low || ext_pin_oe) ? 1'b0 :
		(ext_pin_pullup_en ? 1'b1 : float_reg);
	assign supply_ok = supply_up;
	assign osc_tick  = (div_reg == 8'h00);
endmodule
`default_nettype wire

/* File: testbench/tb_reset_and_config_word_logic.sv */
// Self-checking bench for the reset and configuration word logic
`timescale 1ns/10ps
`default_nettype none
module tb_reset_and_config_word_logic;
	import rcw_pkg::*;
	localparam int POWER_UP_DELAY_TIMER = 20;
	localparam int DIV  = 2;
	logic        sys_clk, rst_n, clk_en, supply_ok, osc_tick, ext_pin_i;
	logic        irq_pending, prog_mode, prog_we, prog_re, pin_low, supply_up;
	logic [3:0]  pls;
	logic [13:0] prog_addr;
	logic [15:0] prog_wdata, prog_rdata, cfg;
	logic        ext_pin_oe, ext_pin_pullup_en, pin_digital_in, prog_mem_erase;
	logic        core_reset, cold_reset, int_osc_run, wake_event, bor_enable;
	logic        wdt_enable, int_osc_8mhz, code_protect_on, clkout_en, por_flag;
	rcw_osc_type osc_mode;
	int          failures, check_count, n, e;
	int          rst_cnt, oe_cnt, wake_cnt, stop_cnt, ers_cnt;
	wire logic   wdt_timeout = pls[0];
	wire logic   sleep_req   = pls[1];
	wire logic   sw_set_por  = pls[2];
	wire logic   bulk_erase  = pls[3];

	rcw_reset_config #(.POWER_UP_DELAY_TIMER_CYCLES(POWER_UP_DELAY_TIMER)) uut (
		.sys_clk, .rst_n, .clk_en, .supply_ok, .osc_tick, .ext_pin_i,
		.ext_pin_oe, .ext_pin_pullup_en, .pin_digital_in, .wdt_timeout,
		.sleep_req, .irq_pending, .sw_set_por, .prog_mode, .prog_addr,
		.prog_we, .prog_wdata, .prog_re, .bulk_erase, .prog_rdata,
		.prog_mem_erase, .core_reset, .cold_reset, .int_osc_run,
		.wake_event, .bor_enable, .wdt_enable, .int_osc_8mhz,
		.code_protect_on, .osc_mode, .clkout_en, .por_flag
	);
	rcw_far_side_model #(.OSC_DIV(DIV)) far (
		.sys_clk, .pin_low, .ext_pin_oe, .ext_pin_pullup_en, .supply_up,
		.ext_pin_i, .supply_ok, .osc_tick
	);

	always #50 sys_clk = !sys_clk;
	// Event counters let scenarios judge what happened between marks
	always @(negedge sys_clk) begin
		rst_cnt  += (core_reset === 1'b1);
		oe_cnt   += (ext_pin_oe !== 1'b0);
		wake_cnt += (wake_event === 1'b1);
		stop_cnt += (int_osc_run === 1'b0);
		ers_cnt  += (prog_mem_erase === 1'b1);
	end

	task automatic summarize();
		if (failures == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge sys_clk);
	endtask
	task automatic zero();
		{rst_cnt, oe_cnt, wake_cnt, stop_cnt, ers_cnt} = '0;
	endtask
	task automatic pulse(input logic [3:0] p);
		@(posedge sys_clk) pls <= p;
		@(posedge sys_clk) pls <= 4'h0;
		@(negedge sys_clk);
	endtask
	task automatic prog_op(input logic w, input logic [13:0] a,
		input logic [15:0] d);
		@(posedge sys_clk);
		prog_we    <= w;
		prog_re    <= !w;
		prog_addr  <= a;
		prog_wdata <= d;
		@(posedge sys_clk);
		prog_we <= 1'b0;
		prog_re <= 1'b0;
		@(negedge sys_clk);
	endtask
	task automatic wait_core(output int k);
		k = 0;
		while (core_reset !== 1'b0) begin
			@(negedge sys_clk);
			k++;
			if (k > 5000) begin
				failures++;
				summarize();
			end
		end
	endtask
	task automatic pin_hold(input int k);
		@(posedge sys_clk) pin_low <= 1'b1;
		tick(k);
		pin_low <= 1'b0;
		tick(2);
		@(negedge sys_clk);
	endtask
	task automatic power_up(input logic [15:0] c, input bit frz);
		@(posedge sys_clk) rst_n <= 1'b0;
		prog_op(1'b1, CFG_ADDR, c);
		tick(4);
		rst_n <= 1'b1;
		if (frz) begin
			tick(6);
			clk_en <= 1'b0;
			tick(10);
			clk_en <= 1'b1;
		end
		wait_core(n);
		n = n + (frz ? 16 : 0);
	endtask
	// Sleep, then wake by interrupt (0), watchdog (1) or pin reset (2)
	task automatic nap(input int how);
		zero();
		pulse(4'h2);
		check(bor_enable, cfg[BOR_SEL_LO]);
		@(posedge sys_clk) irq_pending <= (how == 0);
		if (how == 1)
			pulse(4'h1);
		if (how == 2)
			pin_hold(24);
		tick(6);
		irq_pending <= 1'b0;
		wait_core(n);
		check({wake_cnt == (how != 2), rst_cnt > 0}, {1'b1, how == 2});
	endtask
	function automatic int exp_cyc(input logic [15:0] c);
		return (c[POWER_UP_DELAY_ENABLE_BIT] ? 0 : POWER_UP_DELAY_TIMER) + (c[2:0] < 3'h3 ? OST_TICKS * DIV : 0);
	endfunction

	initial begin
		void'($urandom(32'h43d1));
		{sys_clk, rst_n, pls, irq_pending, prog_mode, prog_we, prog_re} = '0;
		{pin_low, prog_addr, prog_wdata, failures, check_count} = '0;
		{clk_en, supply_up} = 2'h3;
		zero();
		tick(4);
		@(negedge sys_clk);
		check({wdt_enable, clkout_en, bor_enable, code_protect_on, core_reset,
			cold_reset, por_flag, ext_pin_pullup_en, osc_mode}, 16'h076f);
		check(prog_rdata, 16'h0000);
		@(posedge sys_clk) prog_mode <= 1'b1;
		for (int m = 0; m < 8; m++) begin
			cfg = 16'($urandom);
			cfg[2:0] = 3'(m);
			if (m == 4)
				cfg[POWER_UP_DELAY_ENABLE_BIT] = 1'b0;
			power_up(cfg, m == 4);
			e = exp_cyc(cfg) + (m == 4 ? 10 : 0);
			check(n >= e && n <= e + 8, 1'b1);
			check(wdt_enable, cfg[WATCHDOG_ENABLE_BIT]);
			check(int_osc_8mhz, cfg[INTERNAL_OSC_FREQ_SELECT_BIT]);
			check(code_protect_on, !cfg[CP_BIT]);
			check(ext_pin_pullup_en, cfg[PINSEL_BIT]);
			check(bor_enable, cfg[BOR_SEL_HI]);
			check(osc_mode, cfg[2:0]);
			check(clkout_en, cfg[2] && cfg[0]);
			check(cold_reset, 1'b0);
			prog_op(1'b0, CFG_ADDR, 16'h0000);
			check(prog_rdata, cfg | UNIMPL_MASK);
		end
		cfg = 16'hffec;
		power_up(cfg, 1'b0);
		check(por_flag, 1'b0);
		pulse(4'h4);
		check(por_flag, 1'b1);
		zero();
		pin_hold(19);
		check(rst_cnt, 0);
		pin_hold(24);
		check(rst_cnt > 0 && stop_cnt > 0, 1'b1);
		wait_core(n);
		check({n < POWER_UP_DELAY_TIMER, por_flag, cold_reset}, 3'h6);
		zero();
		pulse(4'h1);
		wait_core(n);
		check({rst_cnt > 0, oe_cnt == 0, por_flag}, 3'h7);
		for (int h = 0; h < 3; h++)
			nap(h);
		@(posedge sys_clk) supply_up <= 1'b0;
		tick(30);
		@(negedge sys_clk);
		check(core_reset, 1'b1);
		@(posedge sys_clk) supply_up <= 1'b1;
		wait_core(n);
		check(n >= POWER_UP_DELAY_TIMER && n <= POWER_UP_DELAY_TIMER + 8, 1'b1);
		@(posedge sys_clk) supply_up <= 1'b0;
		tick(3);
		supply_up <= 1'b1;
		tick(10);
		supply_up <= 1'b0;
		tick(3);
		supply_up <= 1'b1;
		wait_core(n);
		check(n >= POWER_UP_DELAY_TIMER && n <= POWER_UP_DELAY_TIMER + 8, 1'b1);
		cfg = 16'hfefb;
		power_up(cfg, 1'b0);
		nap(0);
		check(bor_enable, 1'b1);
		zero();
		@(posedge sys_clk) supply_up <= 1'b0;
		tick(3);
		supply_up <= 1'b1;
		wait_core(n);
		check(rst_cnt > 0 && n < POWER_UP_DELAY_TIMER, 1'b1);
		power_up(16'hffdb, 1'b0);
		zero();
		pin_hold(30);
		check(rst_cnt, 0);
		repeat (2) begin
			@(negedge sys_clk);
			check({pin_digital_in, ext_pin_pullup_en}, {ext_pin_i, 1'b0});
		end
		power_up(16'hff9b, 1'b0);
		zero();
		prog_op(1'b1, CFG_ADDR, 16'hff9b);
		tick(3);
		check(ers_cnt, 0);
		prog_op(1'b1, CFG_ADDR, 16'hffdb);
		tick(3);
		check(ers_cnt, 1);
		cfg = 16'($urandom);
		prog_op(1'b1, CAL_ADDR, cfg);
		prog_op(1'b1, SPACE_BASE + 14'h1, ~cfg);
		prog_op(1'b0, SPACE_BASE + 14'h1, 16'h0000);
		check(prog_rdata, ~cfg);
		zero();
		pulse(4'h8);
		tick(2);
		check(ers_cnt, 1);
		prog_op(1'b0, SPACE_BASE + 14'h1, 16'h0000);
		check(prog_rdata, ERASED_WORD);
		prog_op(1'b0, CAL_ADDR, 16'h0000);
		check(prog_rdata, cfg);
		@(posedge sys_clk) prog_mode <= 1'b0;
		prog_op(1'b0, SPACE_BASE + 14'h1, 16'h0000);
		check(prog_rdata, cfg);
		@(posedge sys_clk) prog_mode <= 1'b1;
		prog_op(1'b0, 14'h0009, 16'h0000);
		check(prog_rdata, cfg);
		prog_op(1'b0, 14'h2010, 16'h0000);
		check(prog_rdata, 16'h0000);
		summarize();
	end
endmodule
`default_nettype wire
